// ===== core/wdt_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: included by the watchdog design files
// Notes:   byte addresses on the register bus
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

`define WDT_CTRL_OFFSET      8'hC0
`define WDT_IRQ_STAT_OFFSET  8'hC4
`define WDT_IRQ_MASK_OFFSET  8'hC8
`define WDT_STATE_OFFSET     8'hCC
`define WDT_CTRL_RESET       8'h10
`define WDT_PRE_MSB          7
`define WDT_PRE_LSB          4
`define WDT_IRB_BIT          3
`define WDT_TOF_BIT          2
`define WDT_ENA_BIT          1
`define WDT_UNL_BIT          0
`define WDT_PRE_IMMEDIATE    4'h8
`define WDT_BASE_EXP         9
`define WDT_CORE_HZ          100000000
`define WDT_LF_HZ            32768
`define WDT_LF_DIV           (`WDT_CORE_HZ / `WDT_LF_HZ / 2)

`endif

// ===== core/wdt_pkg.sv
// Purpose: shared types of the watchdog block
// Assumes: nothing
// Notes:   register contents travel as packed structs
package wdt_pkg;

    // layout of the control register, msb first
    typedef struct packed {
        logic [3:0] prescale;
        logic       irq_instead;
        logic       timeout_flag;
        logic       enable_kick;
        logic       write_unlock;
    } ctrl_t;

    // sticky event bits, same layout in status and mask
    typedef struct packed {
        logic       nmi_event;
        logic       reset_event;
    } events_t;

    // unlock tracker: idle, armed for exactly one following access
    typedef enum logic [1:0] {
        UNL_IDLE  = 2'b01,
        UNL_ARMED = 2'b10
    } unlock_state_t;

endpackage

// ===== core/wdt_lf_tick.sv
// Purpose: low-frequency tick generator from the core clock
// Assumes: core clock at 100 MHz
// Notes:   emits one-cycle tick per low-frequency period
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module wdt_lf_tick #(
    parameter int unsigned HALF_DIV = `WDT_LF_DIV
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // tick out
    output logic      lf_tick
);

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        phase_q;
    logic        phase_d;
    logic        tick_q;
    logic        tick_d;

    // divide down; a tick once per full low-frequency period
    always_comb begin
        cnt_d   = cnt_q + 16'h0001;
        phase_d = phase_q;
        tick_d  = 1'b0;
        if (cnt_q >= 16'(HALF_DIV - 1)) begin
            cnt_d   = 16'h0000;
            phase_d = ~phase_q;
            tick_d  = phase_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cnt_q   <= 16'h0000;
            phase_q <= 1'b0;
            tick_q  <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
            tick_q  <= tick_d;
        end
    end

    assign lf_tick = tick_q;

endmodule
`default_nettype wire

// ===== core/wdt_core.sv
// Purpose: watchdog supervisor with unlock-protected control register
// Assumes: AHB-Lite single word transfers, one slave, OKAY only
// Notes:   timeout counts low-frequency ticks, not core cycles
//
// Behaviour
// - enable clear means no watchdog action
// - missed kick before timeout gives reset/interrupt
// - counter clocked from 32 kHz low-frequency tick
// - timeout is 2^prescale times 2^9 ticks
// - prescale 8 immediate reset, above reserved
// - response bit selects interrupt over reset
// - interrupt ignores global enable, high priority
// - setting enable restarts counter from zero
// - enable cleared by write, reset, supply event
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module wdt_core #(
    parameter int unsigned HALF_DIV  = `WDT_LF_DIV,
    parameter int unsigned CNT_WIDTH = 17
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // system events
    input  wire logic        supply_monitor,
    input  wire logic        wdt_reset_seen,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // watchdog outputs
    output logic             wdt_reset_req,
    output logic             wdt_nmi,
    output logic             irq
);

    wdt_pkg::ctrl_t         ctrl_q;
    wdt_pkg::ctrl_t         ctrl_d;
    wdt_pkg::unlock_state_t unl_q;
    wdt_pkg::unlock_state_t unl_d;
    wdt_pkg::events_t       stat_q;
    wdt_pkg::events_t       stat_d;
    wdt_pkg::events_t       mask_q;
    wdt_pkg::events_t       mask_d;
    logic [CNT_WIDTH-1:0]   cnt_q;
    logic [CNT_WIDTH-1:0]   cnt_d;
    logic [31:0]            rdata_q;
    logic [31:0]            rdata_d;
    logic                   rst_req_q;
    logic                   rst_req_d;
    logic                   nmi_q;
    logic                   nmi_d;
    logic                   irq_q;
    logic                   irq_d;
    logic                   aph_wr_q;
    logic                   aph_wr_d;
    logic                   aph_rd_q;
    logic                   aph_rd_d;
    logic [7:0]             aph_addr_q;
    logic [7:0]             aph_addr_d;
    logic                   lf_tick;
    logic                   timeout;
    logic                   ctrl_wr;
    logic [7:0]             wbyte;

    // lf tick from the divider
    wdt_lf_tick #(
        .HALF_DIV (HALF_DIV)
    ) u_tick (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .lf_tick  (lf_tick)
    );

    // timeout limit in ticks for a prescale code
    function automatic logic [CNT_WIDTH-1:0] limit_of(input logic [3:0] p);
        limit_of = CNT_WIDTH'(1) << (`WDT_BASE_EXP + p[2:0]);
    endfunction

    // decode of the accepted address phase, used in three places
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign wbyte   = hwdata[7:0];
    assign ctrl_wr = aph_wr_q && hit(aph_addr_q, `WDT_CTRL_OFFSET);

    // expiry: enabled, running and limit reached, or immediate code
    always_comb begin
        timeout = 1'b0;
        if (ctrl_q.enable_kick) begin
            if (ctrl_q.prescale == `WDT_PRE_IMMEDIATE) begin
                timeout = 1'b1;
            end else if (!ctrl_q.prescale[3]) begin
                timeout = lf_tick && (cnt_q + CNT_WIDTH'(1)
                          >= limit_of(ctrl_q.prescale));
            end
        end
    end

    // bus address phase capture; zero wait states
    always_comb begin
        aph_wr_d   = 1'b0;
        aph_rd_d   = 1'b0;
        aph_addr_d = aph_addr_q;
        if (hsel && hready && htrans[1]) begin
            aph_wr_d   = hwrite;
            aph_rd_d   = !hwrite;
            aph_addr_d = haddr;
        end
    end

    // unlock tracker: any data phase consumes the arm
    always_comb begin
        unl_d = unl_q;
        case (unl_q)
            wdt_pkg::UNL_IDLE: begin
                if (ctrl_wr && wbyte[`WDT_UNL_BIT]) begin
                    unl_d = wdt_pkg::UNL_ARMED;
                end
            end
            wdt_pkg::UNL_ARMED: begin
                if (aph_wr_q || aph_rd_q) begin
                    unl_d = wdt_pkg::UNL_IDLE;
                end
            end
            default: unl_d = wdt_pkg::UNL_IDLE;
        endcase
    end

    // control register, counter and event logic
    always_comb begin
        ctrl_d    = ctrl_q;
        cnt_d     = cnt_q;
        rst_req_d = 1'b0;
        nmi_d     = nmi_q;
        ctrl_d.write_unlock = (unl_d == wdt_pkg::UNL_ARMED);
        if (ctrl_q.enable_kick && lf_tick) begin
            cnt_d = cnt_q + CNT_WIDTH'(1);
        end
        // protected write: only right after the unlock
        if (ctrl_wr && unl_q == wdt_pkg::UNL_ARMED) begin
            ctrl_d.prescale    = wbyte[`WDT_PRE_MSB:`WDT_PRE_LSB];
            ctrl_d.irq_instead = wbyte[`WDT_IRB_BIT];
            ctrl_d.enable_kick = wbyte[`WDT_ENA_BIT];
            if (!wbyte[`WDT_TOF_BIT]) begin
                ctrl_d.timeout_flag = 1'b0;
            end
            if (wbyte[`WDT_ENA_BIT]) begin
                cnt_d = '0;
            end
        end
        if (!ctrl_d.enable_kick) begin
            cnt_d = '0;
        end
        if (timeout) begin
            ctrl_d.timeout_flag = 1'b1; // set beats clear
            cnt_d = '0;
            if (ctrl_q.irq_instead && !ctrl_q.prescale[3]) begin
                nmi_d = 1'b1;
            end else begin
                rst_req_d          = 1'b1;
                ctrl_d.enable_kick = 1'b0;
            end
        end
        if (supply_monitor) begin
            ctrl_d.enable_kick = 1'b0;
        end
        // kick acknowledges the pending interrupt; not gated by any enable
        if (ctrl_wr && unl_q == wdt_pkg::UNL_ARMED && !timeout) begin
            nmi_d = 1'b0;
        end
    end

    // sticky status, cleared by reading it; set wins
    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (aph_rd_q && hit(aph_addr_q, `WDT_IRQ_STAT_OFFSET)) begin
            stat_d = '0;
        end
        if (aph_wr_q && hit(aph_addr_q, `WDT_IRQ_MASK_OFFSET)) begin
            mask_d = wbyte[1:0];
        end
        if (rst_req_d) begin
            stat_d.reset_event = 1'b1;
        end
        if (nmi_d && !nmi_q) begin
            stat_d.nmi_event = 1'b1;
        end
        irq_d = |(stat_d & mask_d);
    end

    // read data registered for the data phase
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr)
                `WDT_CTRL_OFFSET:     rdata_d = {24'h000000, ctrl_d};
                `WDT_IRQ_STAT_OFFSET: rdata_d = {30'h0, stat_d};
                `WDT_IRQ_MASK_OFFSET: rdata_d = {30'h0, mask_d};
                `WDT_STATE_OFFSET:    rdata_d = {{(32-CNT_WIDTH){1'b0}},
                                                 cnt_d};
                default:              rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // flag survives a watchdog-caused reset: a plain reset or a protected write of zero to it clears it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_q <= wdt_pkg::ctrl_t'(`WDT_CTRL_RESET);
            if (wdt_reset_seen) begin
                ctrl_q.timeout_flag <= 1'b1;
            end
            cnt_q     <= '0;
            unl_q     <= wdt_pkg::UNL_IDLE;
            stat_q    <= '0;
            mask_q    <= '0;
            rst_req_q <= 1'b0;
            nmi_q     <= 1'b0;
            irq_q     <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            aph_wr_q  <= 1'b0;
            aph_rd_q  <= 1'b0;
            aph_addr_q <= 8'h00;
        end else begin
            ctrl_q    <= ctrl_d;
            cnt_q     <= cnt_d;
            unl_q     <= unl_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            rst_req_q <= rst_req_d;
            nmi_q     <= nmi_d;
            irq_q     <= irq_d;
            rdata_q   <= rdata_d;
            aph_wr_q  <= aph_wr_d;
            aph_rd_q  <= aph_rd_d;
            aph_addr_q <= aph_addr_d;
        end
    end

    // outputs straight from flip-flops; hreadyout and hresp tied to constants
    assign hrdata        = rdata_q;
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign wdt_reset_req = rst_req_q;
    assign wdt_nmi       = nmi_q;
    assign irq           = irq_q;

endmodule
`default_nettype wire

// ===== bench/wdt_core_properties.sv
// Purpose: port-level checks of the watchdog core
// Assumes: single clock, synchronous active-low reset
// Notes:   helper flags mark the data phase of taken transfers
`timescale 1ns/10ps
`default_nettype none
module wdt_core_properties #(
    parameter int unsigned HALF_DIV  = 2,
    parameter int unsigned CNT_WIDTH = 17
) (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // outputs
    input wire logic        wdt_reset_req,
    input wire logic        wdt_nmi,
    input wire logic        irq
);
    logic take;
    logic wr_d, wr_q, um_d, um_q, cc_d, cc_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // data-phase markers, so checks line up with registered read data
    always_comb begin
        take = hsel && hready && htrans[1];
        wr_d = take && hwrite && haddr == 8'hC0;
        um_d = take && !hwrite && !(haddr inside {8'hC0, 8'hC4, 8'hC8, 8'hCC});
        // the counter register is wider than a byte, so it is exempt
        cc_d = take && !hwrite && haddr == 8'hCC;
    end
    always_ff @(posedge core_clk) begin
        wr_q <= reset_n && wr_d;
        um_q <= reset_n && um_d;
        cc_q <= reset_n && cc_d;
    end
    a_zero_wait: assert property (hreadyout) else $error("wait state seen");
    a_okay_only: assert property (!hresp) else $error("error response seen");
    a_upper_zero: assert property (!cc_q |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (um_q |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_req_pulse: assert property (wdt_reset_req |=> !wdt_reset_req)
        else $error("reset request longer than one cycle");
    a_resp_excl: assert property (!(wdt_nmi && wdt_reset_req))
        else $error("interrupt and reset together");
    a_reset_quiet: assert property ($rose(reset_n) |->
        !wdt_nmi && !wdt_reset_req && !irq) else $error("outputs after reset");
    // the drop shows one edge after the write's data phase
    a_nmi_holds: assert property ($fell(wdt_nmi) |-> $past(wr_q))
        else $error("interrupt dropped without control write");
    c_nmi: cover property (wdt_nmi);
    c_req: cover property (wdt_reset_req);
    c_irq: cover property (irq);
endmodule
bind wdt_core wdt_core_properties #(.HALF_DIV(HALF_DIV), .CNT_WIDTH(CNT_WIDTH))
    i_props (.*);
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: self-checking bench of the watchdog core
// Assumes: zero-wait slave, fast low-frequency tick in simulation
// Notes:   timings are compared as ratios, tick phase adds jitter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic core_clk = 0, reset_n = 0, supply_monitor = 0, wdt_reset_seen = 0;
    logic hsel = 0, hwrite = 0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, r;
    wire hready;
    logic hreadyout, hresp, wdt_reset_req, wdt_nmi, irq;
    int miscompares = 0, checks_done = 0, cyc = 0, t0, t1, n, i;
    // rows: address, write, data, expected read
    logic [7:0] ra[8] = '{8'hC0, 8'hC4, 8'hC8, 8'hC8, 8'hD0, 8'hD0, 8'hC0, 8'hC0};
    logic rw[8] = '{0, 0, 1, 0, 0, 1, 1, 0};
    logic [31:0] rx[8] = '{32'h10, 32'h0, 32'h3, 32'h3, 32'h0, 32'h55,
                           32'h2, 32'h10};
    assign hready = hreadyout;
    wdt_core #(.HALF_DIV(2)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .supply_monitor(supply_monitor), .wdt_reset_seen(wdt_reset_seen),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .wdt_reset_req(wdt_reset_req),
        .wdt_nmi(wdt_nmi), .irq(irq));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // hang guard, well above the expected run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    // one single transfer, held until hready is sampled high
    task automatic bus(input logic [7:0] a, input logic [31:0] d,
                       input logic w, output logic [31:0] q);
        hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 32'h0, 0, r);
        chk("read", r, e);
    endtask
    // unlock write, then the real write as the very next transfer
    task automatic wc(input logic [7:0] v);
        bus(8'hC0, 32'h1, 1, r);
        bus(8'hC0, {24'h0, v}, 1, r);
    endtask
    task automatic wev(input int lim, output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            #1 k++;
        end while (wdt_nmi !== 1'b1 && wdt_reset_req !== 1'b1 && k < lim);
    endtask
    task automatic rst(input logic seen);
        reset_n <= 0; wdt_reset_seen <= seen;
        repeat (8) @(posedge core_clk);
        reset_n <= 1; wdt_reset_seen <= 0;
    endtask
    initial begin
        rst(0);
        for (i = 0; i < 8; i++) begin
            bus(ra[i], rx[i], rw[i], r);
            if (!rw[i]) chk("row", r, rx[i]);
        end
        $display("register rows done");
        wc(8'h0A); wev(20000, t0);
        chk("nmi", wdt_nmi, 1);
        chk("irq", irq, 1);
        rd(8'hC4, 32'h2); rd(8'hC4, 32'h0); @(posedge core_clk); #1;
        chk("irq clr", irq, 0);
        rd(8'hC0, 32'h0E);
        wc(8'h1A); wev(20000, t1);
        chk("double", t1 > 2 * t0 - 24 && t1 < 2 * t0 + 24, 1);
        bus(8'hC0, 32'h1, 1, r); rd(8'hC8, 32'h3);
        bus(8'hC0, 32'h0, 1, r); rd(8'hC0, 32'h1E);
        $display("interrupt mode done");
        bus(8'hC4, 32'h0, 0, r); wc(8'h02); wev(20000, n);
        chk("rst req", wdt_reset_req, 1);
        chk("t same", n > t0 - 24 && n < t0 + 24, 1);
        rd(8'hC0, 32'h04); rd(8'hC4, 32'h1);
        wc(8'h82); wev(64, n);
        chk("immediate", wdt_reset_req, 1);
        wc(8'h92); wev(6000, n);
        chk("reserved", n, 6000);
        wc(8'h0A); wc(8'h08); wev(6000, n);
        chk("disabled", n, 6000);
        wc(8'h0A); supply_monitor <= 1; @(posedge core_clk);
        supply_monitor <= 0; wev(6000, n);
        chk("supply", n, 6000); rd(8'hC0, 32'h08);
        rd(8'hCC, 32'h0);
        $display("enable control done");
        rst(1); rd(8'hC0, 32'h14);
        rst(0); rd(8'hC0, 32'h10);
        $display("reset flag done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
